// ### common/sttg_defines.vh
// Purpose: constants for the smbus target timeout guard
// Assumes: 50 MHz system clock
// Notes:   times in microseconds, counts derived from the clock rate
`ifndef STTG_DEFINES_VH
`define STTG_DEFINES_VH

// clock rate in kHz
`define STTG_CLK_KHZ            50000
// bus low timeout limits, microseconds
`define STTG_TIMEOUT_MIN_US     25000
`define STTG_TIMEOUT_MAX_US     35000
// clock high period limit, microseconds
`define STTG_HIGH_MAX_US        50
// least time rounds up, longest rounds down
`define STTG_TIMEOUT_MIN_CYC    ((`STTG_TIMEOUT_MIN_US * `STTG_CLK_KHZ + 999) / 1000)
`define STTG_TIMEOUT_MAX_CYC    ((`STTG_TIMEOUT_MAX_US * `STTG_CLK_KHZ) / 1000)
// threshold chosen midway between the limits: 30 ms
`define STTG_TIMEOUT_CYC        ((`STTG_TIMEOUT_MIN_CYC + `STTG_TIMEOUT_MAX_CYC) / 2)
`define STTG_IDLE_CYC           ((`STTG_HIGH_MAX_US * `STTG_CLK_KHZ + 999) / 1000 + 1)
`define STTG_CNT_W              21

`endif

// ### core/sttg_low_timer.v
// Purpose: measures how long one bus line has stayed low
// Assumes: line input already synchronised to clk_i
// Notes:   count restarts on every transition of the line
`timescale 1ns/100ps
`include "sttg_defines.vh"

module sttg_low_timer #(
    parameter CNT_W     = `STTG_CNT_W,
    parameter THRESHOLD = `STTG_TIMEOUT_CYC
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             sys_rst_i,
    // control
    input  wire             enable_i,
    input  wire             line_i,
    // result
    output reg              expired_o
);

    reg  [CNT_W-1:0] cnt_q;
    reg              line_q;

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q     <= {CNT_W{1'b0}};
            line_q    <= 1'b1;
            expired_o <= 1'b0;
        end else if (!enable_i) begin
            cnt_q     <= {CNT_W{1'b0}};
            line_q    <= 1'b1;
            expired_o <= 1'b0;
        end else begin
            line_q <= line_i;
            if (line_i != line_q || line_i) begin // [R8]
                cnt_q     <= {CNT_W{1'b0}};
                expired_o <= 1'b0;
            end else if (cnt_q == THRESHOLD[CNT_W-1:0] - 1'b1) begin // [R8]
                expired_o <= 1'b1;
            end else if (!expired_o) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule // sttg_low_timer

// ### core/sttg_timeout_guard.v
// Purpose: bus protection for an smbus target port
// Assumes: scl/sda arrive asynchronously from pins, open drain
// Notes:   the target engine is outside; this block aborts it
// Behaviour
// [R1] data line held low too long aborts, releases
// [R2] clock low past minimum timeout may abort
// [R3] host issues stop after clock-low timeout
// [R4] after timeout, ready for start before max; code leaves abort only when the offending line rises, with no time limit
// [R5] forcing party holds clock low at least max
// [R6] bus idle after long both-high interval
// [R7] ignore bus unless power good is high
// [R8] counter restarts on edge, threshold within limits
`timescale 1ns/100ps
`include "sttg_defines.vh"

module sttg_timeout_guard #(
    parameter TIMEOUT_CYC = `STTG_TIMEOUT_CYC,
    parameter IDLE_CYC    = `STTG_IDLE_CYC
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       sys_rst_i,
    // power
    input  wire       power_good_in_i,
    // bus pins
    input  wire       scl_i,
    input  wire       sda_i,
    // from the target engine: its wish to pull the lines low
    input  wire       eng_scl_low_i,
    input  wire       eng_sda_low_i,
    // pin drivers, open drain
    output wire       scl_o,
    output wire       scl_oe_o,
    output wire       sda_o,
    output wire       sda_oe_o,
    // to the target engine
    output wire       bus_active_o,
    output wire       eng_reset_o,
    output reg        timeout_o,
    output reg        start_o,
    output reg        stop_o,
    output reg        bus_idle_o
);

    // ******************************
    // synchronisers
    // ******************************
    reg  [1:0] scl_sync_q;
    reg  [1:0] sda_sync_q;
    reg  [1:0] pg_sync_q;
    reg        scl_q;
    reg        sda_q;

    // lines reset to their idle level so no false edge follows reset
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_q      <= scl_sync_q[1];
            sda_q      <= sda_sync_q[1];
        end
    end

    // power good resets low so the guard always starts switched off
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pg_sync_q <= 2'h0;
        end else begin
            pg_sync_q <= {pg_sync_q[0], power_good_in_i}; // [R7]
        end
    end

    wire scl_s = scl_sync_q[1];
    wire sda_s = sda_sync_q[1];
    wire pg_s  = pg_sync_q[1];

    // ******************************
    // low timers
    // ******************************
    wire scl_exp;
    wire sda_exp;

    // threshold sits between the minimum and maximum limits
    sttg_low_timer #(
        .CNT_W     (`STTG_CNT_W),
        .THRESHOLD (TIMEOUT_CYC)
    ) u_scl_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .enable_i  (pg_s),
        .line_i    (scl_s),
        .expired_o (scl_exp)
    ); // [R2]

    sttg_low_timer #(
        .CNT_W     (`STTG_CNT_W),
        .THRESHOLD (TIMEOUT_CYC)
    ) u_sda_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .enable_i  (pg_s),
        .line_i    (sda_s),
        .expired_o (sda_exp)
    ); // [R1]

    // ******************************
    // bus conditions
    // ******************************
    // start and stop differ only in the level the data line moves to
    function cond_seen;
        input scl_now;
        input scl_was;
        input sda_was;
        input sda_now;
        input sda_to;
        begin
            cond_seen = scl_now & scl_was & (sda_was == ~sda_to) & (sda_now == sda_to);
        end
    endfunction

    wire start_cond = cond_seen(scl_s, scl_q, sda_q, sda_s, 1'b0);
    wire stop_cond  = cond_seen(scl_s, scl_q, sda_q, sda_s, 1'b1);

    // ******************************
    // abort state
    // ******************************
    localparam ST_OFF   = 2'b00;
    localparam ST_WATCH = 2'b01;
    localparam ST_ABORT = 2'b10;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (pg_s)
                    state_d = ST_WATCH;
            end
            ST_WATCH: begin
                if (scl_exp || sda_exp)
                    state_d = ST_ABORT; // [R1] [R2]
            end
            ST_ABORT: begin
                // leave as soon as the offending line rises, even when
                // that is after the maximum timeout, ready for a start
                if (!scl_exp && !sda_exp)
                    state_d = ST_WATCH; // [R4]
            end
            default: state_d = ST_OFF;
        endcase
        // losing power good overrides every state
        if (!pg_s)
            state_d = ST_OFF; // [R7]
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ******************************
    // event pulses
    // ******************************
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timeout_o <= 1'b0;
            start_o   <= 1'b0;
            stop_o    <= 1'b0;
        end else begin
            // one pulse per abort, taken on the entry edge only
            timeout_o <= (state_q == ST_WATCH) && (state_d == ST_ABORT); // [R1] [R2]
            start_o   <= pg_s && start_cond; // [R7]
            stop_o    <= pg_s && stop_cond; // [R7]
        end
    end

    // ******************************
    // idle detect
    // ******************************
    localparam IDLE_W = 12;

    reg  [IDLE_W-1:0] idle_cnt_q;

    // any low or loss of power good restarts the high count
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_cnt_q <= {IDLE_W{1'b0}};
            bus_idle_o <= 1'b0;
        end else if (!pg_s || !scl_s || !sda_s) begin
            idle_cnt_q <= {IDLE_W{1'b0}};
            bus_idle_o <= 1'b0;
        end else if (idle_cnt_q == IDLE_CYC[IDLE_W-1:0]) begin
            // counter parks here; IDLE_CYC must fit in IDLE_W bits
            bus_idle_o <= 1'b1; // [R6]
        end else begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    // ******************************
    // pin drive
    // ******************************
    assign bus_active_o = (state_q == ST_WATCH);
    // engine held in reset while aborting or without power good
    assign eng_reset_o  = ~bus_active_o; // [R4] [R7]
    // lines released while aborting; engine drive only when active
    // open drain: data stays low, only the enable moves
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = bus_active_o & eng_scl_low_i; // [R1] [R2]
    assign sda_oe_o = bus_active_o & eng_sda_low_i; // [R1]

endmodule // sttg_timeout_guard

// ### verification/sttg_timeout_guard_properties.sv
// Purpose: timeout guard assertions
// Assumes: small TIMEOUT_CYC in simulation
// Notes:   counters measure low time at the pins
`timescale 1ns/100ps
module sttg_timeout_guard_properties #(parameter TIMEOUT_CYC = 100, parameter IDLE_CYC = 20) (
    // clock, reset, power and pins
    input wire clk_i, sys_rst_i, power_good_in_i, scl_i, sda_i, eng_scl_low_i, eng_sda_low_i,
    // guard outputs
    input wire scl_o, scl_oe_o, sda_o, sda_oe_o, bus_active_o, eng_reset_o, timeout_o, start_o, stop_o,
    input wire bus_idle_o);
    int lo_q;
    int sl_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // either line low, so a valid lower bound for any abort
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lo_q <= 0;
            sl_q <= 0;
        end else begin
            lo_q <= (scl_i && sda_i) ? 0 : lo_q + 1;
            sl_q <= scl_i ? 0 : sl_q + 1;
        end
    end
    pg_off_a: assert property (!power_good_in_i [*5] |-> eng_reset_o && !bus_active_o && !timeout_o && !start_o)
        else $error("activity while power good is low");
    abort_release_a: assert property (timeout_o |-> eng_reset_o && !scl_oe_o && !sda_oe_o)
        else $error("lines held during abort");
    pulse_once_a: assert property (timeout_o |=> !timeout_o)
        else $error("timeout pulse too long");
    min_wait_a: assert property (timeout_o |-> lo_q >= TIMEOUT_CYC + 1)
        else $error("abort before threshold");
    max_wait_a: assert property (sl_q == TIMEOUT_CYC + 6 |-> !bus_active_o)
        else $error("no abort after threshold");
    rearm_a: assert property ((!bus_active_o && power_good_in_i && scl_i && sda_i) [*6] |-> bus_active_o)
        else $error("not rearmed");
    open_drain_a: assert property (!scl_o && !sda_o)
        else $error("pin data not low");
    drive_pass_a: assert property (bus_active_o |-> {scl_oe_o, sda_oe_o} == {eng_scl_low_i, eng_sda_low_i})
        else $error("engine drive not passed");
    cover property (stop_o);
    cover property (timeout_o);
    cover property (start_o);
    cover property (bus_idle_o);
endmodule // sttg_timeout_guard_properties
bind sttg_timeout_guard sttg_timeout_guard_properties #(.TIMEOUT_CYC(TIMEOUT_CYC), .IDLE_CYC(IDLE_CYC)) u_props (.*);

// ### verification/sttg_host_model.sv
// Purpose: smbus host side with pull-ups
// Assumes: bench decides how long the host holds a line
// Notes:   a released line reads high, never the last value
`timescale 1ns/100ps
module sttg_host_model (
    // host wishes and guard drivers
    input  wire scl_low_i, sda_low_i, dut_scl_oe_i, dut_sda_oe_i,
    // wired-and bus
    output wire scl_o, sda_o);
    assign scl_o = ~(scl_low_i | dut_scl_oe_i);
    assign sda_o = ~(sda_low_i | dut_sda_oe_i);
endmodule // sttg_host_model

// ### verification/sttg_timeout_guard_test.sv
// Purpose: self-checking bench for the timeout guard
// Assumes: threshold shortened to 100 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
module sttg_timeout_guard_test;
    localparam int TO = 100;
    logic clk_i = 0, sys_rst_i = 1, pg = 0, h_scl = 0, h_sda = 0, e_scl = 0, e_sda = 0;
    wire scl, sda, scl_oe, sda_oe, act, ers, tmo, st, sp, idl;
    int error_cnt = 0, checks_done = 0, n_to = 0, n_st = 0, n_sp = 0;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_to <= n_to + (tmo === 1'b1);
        n_st <= n_st + (st === 1'b1);
        n_sp <= n_sp + (sp === 1'b1);
    end
    sttg_host_model host (.scl_low_i(h_scl), .sda_low_i(h_sda), .dut_scl_oe_i(scl_oe), .dut_sda_oe_i(sda_oe),
        .scl_o(scl), .sda_o(sda));
    sttg_timeout_guard #(.TIMEOUT_CYC(TO), .IDLE_CYC(20)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .power_good_in_i(pg), .scl_i(scl), .sda_i(sda), .eng_scl_low_i(e_scl), .eng_sda_low_i(e_sda),
        .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe), .bus_active_o(act), .eng_reset_o(ers),
        .timeout_o(tmo), .start_o(st), .stop_o(sp), .bus_idle_o(idl));
    task automatic chk(input logic [63:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic t_frame;
        cyc(26);
        chk(idl, 1);
        h_sda = 1; cyc(3); h_scl = 1; cyc(3);
        chk(idl, 0);
        e_sda = 1;
        e_scl = 1;
        cyc(1);
        chk({scl_oe, sda_oe}, 2'h3);
        e_sda = 0;
        e_scl = 0;
        h_scl = 0; cyc(3); h_sda = 0; cyc(5);
        chk({n_st, n_sp}, 64'h0000000100000001);
    endtask
    task automatic t_stuck(input bit on_scl);
        int k;
        int n0;
        if (on_scl) h_scl = 1; else h_sda = 1;
        for (k = 0; k < 200 && tmo !== 1'b1; k++) cyc(1);
        chk(k >= TO && k <= TO + 5, 1);
        e_scl = 1; e_sda = 1; cyc(1);
        chk({scl_oe, sda_oe, ers}, 3'h1);
        // abort already seen; line held 20 more cycles before release
        cyc(20);
        h_scl = 0; h_sda = 0; e_scl = 0; e_sda = 0; cyc(6);
        chk(act, 1);
        if (on_scl) begin
            // host closes the abandoned transfer with a stop
            n0 = n_sp;
            h_scl = 1;
            cyc(2);
            h_sda = 1;
            cyc(3);
            h_scl = 0;
            cyc(3);
            h_sda = 0;
            cyc(5);
            chk(n_sp - n0, 1);
        end
    endtask
    task automatic t_restart;
        int n0;
        n0 = n_to;
        h_scl = 1; cyc(TO - 10); h_scl = 0; cyc(2); h_scl = 1; cyc(TO - 10); h_scl = 0; cyc(5);
        chk(n_to - n0, 0);
    endtask
    task automatic t_power_off;
        int n0;
        n0 = n_to + n_st;
        pg = 0; cyc(3); h_sda = 1; cyc(3); h_scl = 1; cyc(TO + 20);
        e_sda = 1; cyc(1);
        chk({ers, act, sda_oe}, 3'h4);
        chk(n_to + n_st - n0, 0);
        h_scl = 0; h_sda = 0; e_sda = 0; cyc(3); pg = 1; cyc(6);
        chk(act, 1);
    endtask
    task automatic conclude;
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        cyc(8); sys_rst_i = 0; pg = 1; cyc(6);
        t_frame;
        t_stuck(1);
        t_stuck(0);
        t_restart;
        t_power_off;
        conclude;
    end
    initial begin
        cyc(5000); error_cnt++; conclude;
    end
endmodule // sttg_timeout_guard_test
